//--- verilog/config_control_instr_exec.sv
// Overview of operation
// - self-load from scratchpad into four registers, any state but 3, per inhibit bits
// - external load only in state 3; otherwise target registers untouched
// - select word picks one of 3 I/O units, 4 CPUs or 15 memory modules
// - external select cannot address the issuing CPU itself
// - external load reads memory at effective address placed in address register
// - external load/store send a direct-control order with select; inhibits only on load, store sends them as zero
// - self-store works in any state, writes own registers to memory
// - external store only in state 3
// - store writes all four registers of selected unit at effective address
// - enter-reconfiguration accepted only in state 2
// - enter-reconfiguration sets state-3 bit in one step
// - power-down only in state 3
// - power-down order goes over direct control, target must be halted
// - leaving stop clears address register, reads restart word at the address held in the prefix register
// - after restart word, hand over to the fetch microroutine
// - state codes 000, 001, 010, 110; top bit only in CPUs
// - a halted element finishes its operation; memory holds busy
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module config_control_instr_exec
	import cfg_ctrl_pkg::*;
#(
	parameter int SELF_CPU = 0
) (
	input wire logic sys_clk, // 125 MHz clock
	input wire logic sys_rst, // async reset, active high
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic stop_release, // stopped state ends (pin)
	output mem_req_t mem_req, // memory request, held until mem_ack
	input wire logic mem_ack, // memory cycle done, same clock
	input wire logic [31:0] mem_rdata, // memory read data, valid with mem_ack
	output dctl_t dctl, // direct control order, held until dctl_ack
	input wire logic dctl_ack, // order taken by target, same clock
	input wire logic dctl_tgt_halted, // target in state 1, with dctl_ack
	input wire logic [31:0] ext_reg_rdata, // target register word, with dctl_ack
	output logic fetch_start // one-cycle start of fetch microroutine
);

	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_SELF_LD = 4'b0001,
		S_EXT_RD = 4'b0010,
		S_EXT_ORD = 4'b0011,
		S_ST_GET = 4'b0100,
		S_ST_WR = 4'b0101,
		S_PWR = 4'b0110,
		S_RESTART = 4'b0111,
		S_FETCH = 4'b1000
	} fsm_t;

	fsm_t st_r;
	opcode_t op_r;
	logic [31:0] operand_r, eaddr_r, xfer_r, mar_r, restart_r, status_r;
	logic [31:0] ccu_r [4];
	logic [31:0] spm_r [4];
	logic [1:0] idx_r;
	logic busy;
	logic [2:0] cur_state;
	logic [SEL_W-1:0] sel_word;
	logic sel_ok;
	logic [31:0] cmd_wdata;
	logic cmd_wr;
	logic [2:0] rel_sync_r;
	logic aw_hold_r, w_hold_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic wr_go;

	assign busy = (st_r != S_IDLE);
	assign cur_state = ccu_r[3][STATE3_BIT:STATE_LSB];
	assign sel_word = xfer_r[SEL_W-1:0];
	// one select bit, never the own CPU slot
	assign sel_ok = ($countones(sel_word) == 1) && !sel_word[NUM_MM + SELF_CPU];

	// write channel: take address and data in either order
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_r > ADDR_MAR) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_hold_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end
	end
	assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign cmd_wr = wr_go && (aw_addr_r == ADDR_CMD) && !busy;
	assign cmd_wdata = w_data_r;

	// software-owned operand registers and scratchpad
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			operand_r <= 32'h0;
			eaddr_r <= 32'h0;
			for (int i = 0; i < 4; i++) spm_r[i] <= 32'h0;
		end else if (wr_go && !busy) begin
			if (aw_addr_r == ADDR_OPERAND) operand_r <= w_data_r;
			if (aw_addr_r == ADDR_EADDR) eaddr_r <= w_data_r;
			for (int i = 0; i < 4; i++)
				if (aw_addr_r == ADDR_SPM_BASE + 8'(4 * i)) spm_r[i] <= w_data_r;
		end
	end

	// read channel
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				case (s_axi_araddr)
					ADDR_CMD: s_axi_rdata <= {29'h0, op_r};
					ADDR_OPERAND: s_axi_rdata <= operand_r;
					ADDR_EADDR: s_axi_rdata <= eaddr_r;
					// busy follows the sequencer, so a refused command never looks pending
					ADDR_STATUS: s_axi_rdata <= {status_r[31:1], busy};
					ADDR_XLAT1: s_axi_rdata <= ccu_r[0];
					ADDR_XLAT2: s_axi_rdata <= ccu_r[1];
					ADDR_PREF: s_axi_rdata <= ccu_r[2];
					ADDR_COMM: s_axi_rdata <= ccu_r[3];
					ADDR_RESTART: s_axi_rdata <= restart_r;
					ADDR_MAR: s_axi_rdata <= mar_r;
					default: begin
						if (s_axi_araddr >= ADDR_SPM_BASE && s_axi_araddr < ADDR_RESTART) begin
							s_axi_rdata <= spm_r[s_axi_araddr[3:2]];
						end else begin
							s_axi_rdata <= 32'h0;
							s_axi_rresp <= RESP_SLVERR;
						end
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// release of the stopped state comes from a pin
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) rel_sync_r <= 3'b000;
		else rel_sync_r <= {rel_sync_r[1:0], stop_release};
	end

	// instruction sequencer
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= S_IDLE;
			op_r <= OP_NONE;
			idx_r <= 2'd0;
			xfer_r <= 32'h0;
			mar_r <= 32'h0;
			restart_r <= 32'h0;
			status_r <= 32'h0;
			for (int i = 0; i < 4; i++) ccu_r[i] <= 32'h0;
			ccu_r[3][STATE3_BIT:STATE_LSB] <= ST2;
			mem_req <= '0;
			dctl <= '0;
			fetch_start <= 1'b0;
		end else begin
			fetch_start <= 1'b0;
			case (st_r)
				S_IDLE: begin
					if (rel_sync_r[2] && !rel_sync_r[1]) begin
						mar_r <= 32'h0;
						mem_req <= '{req: 1'b1, we: 1'b0, addr: ccu_r[2], wdata: 32'h0};
						st_r <= S_RESTART;
					end else if (cmd_wr) begin
						op_r <= opcode_t'(cmd_wdata[2:0]);
						idx_r <= 2'd0;
						xfer_r <= spm_r[0];
						status_r <= 32'h0; // error flags of the previous command clear here
						case (opcode_t'(cmd_wdata[2:0]))
							OP_LOAD_SELF: st_r <= (cur_state != ST3) ? S_SELF_LD : S_IDLE;
							OP_LOAD_EXT, OP_STORE_EXT: begin
								if (cur_state == ST3) begin
									mar_r <= eaddr_r;
									st_r <= (cmd_wdata[2:0] == OP_LOAD_EXT) ? S_EXT_RD : S_ST_GET;
								end else st_r <= S_IDLE;
							end
							OP_STORE_SELF: begin
								mar_r <= eaddr_r;
								st_r <= S_ST_WR;
							end
							OP_ENTER_RECONF:
								if (cur_state == ST2) ccu_r[3][STATE3_BIT] <= 1'b1;
							OP_POWER_DOWN, OP_POWER_UP:
								st_r <= (cur_state == ST3) ? S_PWR : S_IDLE;
							default: st_r <= S_IDLE;
						endcase
						if (cmd_wdata[2:0] == OP_ENTER_RECONF || cmd_wdata[2:0] == OP_NONE)
							status_r <= 32'h0;
					end
				end
				S_SELF_LD: begin
					if (!operand_r[idx_r]) begin
						if (idx_r != 2'd3) ccu_r[idx_r] <= xfer_r;
						else begin
							if (!operand_r[INH_STATE])
								ccu_r[3][STATE3_BIT:STATE_LSB] <= xfer_r[STATE3_BIT:STATE_LSB];
							if (!operand_r[INH_COMM])
								ccu_r[3][STATE_LSB-1:0] <= xfer_r[STATE_LSB-1:0];
						end
					end else if (idx_r == 2'd3 && !operand_r[INH_COMM]) begin
						ccu_r[3][STATE_LSB-1:0] <= xfer_r[STATE_LSB-1:0];
					end
					xfer_r <= spm_r[2'(idx_r + 2'd1)];
					idx_r <= 2'(idx_r + 2'd1);
					if (idx_r == 2'd3) begin
						st_r <= S_IDLE;
						status_r <= 32'h0;
					end
				end
				S_EXT_RD: begin
					if (!sel_ok) begin
						st_r <= S_IDLE;
						status_r <= 32'h2;
					end else if (!mem_req.req) begin
						mem_req <= '{req: 1'b1, we: 1'b0,
							addr: 32'(mar_r + 32'(idx_r)), wdata: 32'h0};
					end else if (mem_ack) begin
						mem_req <= '0;
						dctl <= '{valid: 1'b1, order: ORD_LOAD, select: sel_word,
							inhibit: xfer_r[INH_LSB+4:INH_LSB]};
						restart_r <= mem_rdata;
						st_r <= S_EXT_ORD;
					end
				end
				S_EXT_ORD: begin
					if (dctl_ack) begin
						dctl <= '0;
						idx_r <= 2'(idx_r + 2'd1);
						st_r <= (idx_r == 2'd3) ? S_IDLE : S_EXT_RD;
						if (idx_r == 2'd3) status_r <= 32'h0;
					end
				end
				S_ST_GET: begin
					if (!sel_ok) begin
						st_r <= S_IDLE;
						status_r <= 32'h2;
					end else if (!dctl.valid) begin
						dctl <= '{valid: 1'b1, order: ORD_STORE, select: sel_word,
							inhibit: 5'h00};
					end else if (dctl_ack) begin
						dctl <= '0;
						mem_req <= '{req: 1'b1, we: 1'b1,
							addr: 32'(mar_r + 32'(idx_r)), wdata: ext_reg_rdata};
						st_r <= S_ST_WR;
					end
				end
				S_ST_WR: begin
					if (!mem_req.req) begin
						mem_req <= '{req: 1'b1, we: 1'b1,
							addr: 32'(mar_r + 32'(idx_r)), wdata: ccu_r[idx_r]};
					end else if (mem_ack) begin
						mem_req <= '0;
						idx_r <= 2'(idx_r + 2'd1);
						if (idx_r == 2'd3) begin
							st_r <= S_IDLE;
							status_r <= 32'h0;
						end else if (op_r == OP_STORE_EXT) st_r <= S_ST_GET;
					end
				end
				S_PWR: begin
					if (!sel_ok) begin
						st_r <= S_IDLE;
						status_r <= 32'h2;
					end else if (!dctl.valid) begin
						dctl <= '{valid: 1'b1,
							order: (op_r == OP_POWER_DOWN) ? ORD_PDOWN : ORD_PUP,
							select: sel_word, inhibit: 5'h00};
					end else if (dctl_ack) begin
						dctl <= '0;
						st_r <= S_IDLE;
						// a target not halted ignores power-down
						status_r <= (op_r == OP_POWER_DOWN && !dctl_tgt_halted) ? 32'h4 : 32'h0;
					end
				end
				S_RESTART: begin
					if (mem_ack) begin
						mem_req <= '0;
						restart_r <= mem_rdata;
						st_r <= S_FETCH;
					end
				end
				S_FETCH: begin
					fetch_start <= 1'b1;
					st_r <= S_IDLE;
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end

endmodule // config_control_instr_exec

//--- verilog/cfg_ctrl_pkg.sv
package cfg_ctrl_pkg;
	// AXI4-Lite register byte offsets
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_OPERAND = 8'h04;
	localparam logic [7:0] ADDR_EADDR = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_XLAT1 = 8'h10;
	localparam logic [7:0] ADDR_XLAT2 = 8'h14;
	localparam logic [7:0] ADDR_PREF = 8'h18;
	localparam logic [7:0] ADDR_COMM = 8'h1c;
	localparam logic [7:0] ADDR_SPM_BASE = 8'h20;
	localparam logic [7:0] ADDR_RESTART = 8'h30;
	localparam logic [7:0] ADDR_MAR = 8'h34;

	// instruction opcodes written to the command register
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_LOAD_SELF = 3'b001,
		OP_LOAD_EXT = 3'b010,
		OP_STORE_SELF = 3'b011,
		OP_STORE_EXT = 3'b100,
		OP_ENTER_RECONF = 3'b101,
		OP_POWER_DOWN = 3'b110,
		OP_POWER_UP = 3'b111
	} opcode_t;

	// state field codes of the comm-state register
	localparam logic [2:0] ST0 = 3'b000;
	localparam logic [2:0] ST1 = 3'b001;
	localparam logic [2:0] ST2 = 3'b010;
	localparam logic [2:0] ST3 = 3'b110;
	localparam int STATE_LSB = 29;
	localparam int STATE3_BIT = 31;

	// select word layout: 22 one-hot selects, 5 inhibits above them
	localparam int NUM_IOC = 3;
	localparam int NUM_CPU = 4;
	localparam int NUM_MM = 15;
	localparam int SEL_W = NUM_IOC + NUM_CPU + NUM_MM;
	localparam int INH_LSB = 22;
	localparam int INH_XLAT1 = 0;
	localparam int INH_XLAT2 = 1;
	localparam int INH_PREF = 2;
	localparam int INH_STATE = 3;
	localparam int INH_COMM = 4;

	// order codes on the direct control lines
	localparam logic [1:0] ORD_LOAD = 2'h0;
	localparam logic [1:0] ORD_STORE = 2'h1;
	localparam logic [1:0] ORD_PDOWN = 2'h2;
	localparam logic [1:0] ORD_PUP = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic valid;
		logic [1:0] order;
		logic [SEL_W-1:0] select;
		logic [4:0] inhibit;
	} dctl_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_req_t;
endpackage

//--- verification/cfg_exec_properties.sv
`timescale 1ns/1ns
module cfg_exec_properties
	import cfg_ctrl_pkg::*;
#(
	parameter int SELF_CPU = 0
) (
	input wire logic sys_clk, // clock
	input wire logic sys_rst, // async reset
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic stop_release, // stop pin
	input wire mem_req_t mem_req, // memory request
	input wire logic mem_ack, // memory ack
	input wire dctl_t dctl, // direct control order
	input wire logic dctl_ack, // order taken
	input wire logic fetch_start // fetch start pulse
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_mem_hold;
		mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req);
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory request changed early");
	property p_dctl_hold;
		dctl.valid && !dctl_ack |=> dctl.valid && $stable(dctl);
	endproperty
	a_dctl_hold: assert property (p_dctl_hold) else $error("order changed early");
	property p_sel_onehot;
		dctl.valid |-> $onehot(dctl.select);
	endproperty
	a_sel_onehot: assert property (p_sel_onehot) else $error("select not one-hot");
	property p_not_self;
		dctl.valid |-> !dctl.select[NUM_MM + SELF_CPU];
	endproperty
	a_not_self: assert property (p_not_self) else $error("order aimed at own cpu");
	property p_fetch_pulse;
		fetch_start |=> !fetch_start;
	endproperty
	a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch start too long");
	property p_restart_rd;
		$fell(stop_release) |-> ##[1:16] (mem_req.req && !mem_req.we);
	endproperty
	a_restart_rd: assert property (p_restart_rd) else $error("no restart read");
	property p_b_once;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_once: assert property (p_b_once) else $error("write response repeated");
	property p_r_once;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_once: assert property (p_r_once) else $error("read response repeated");
	c_load: cover property (dctl.valid && dctl_ack && dctl.order == ORD_LOAD);
	c_store: cover property (mem_req.req && mem_req.we && mem_ack);
	c_fetch: cover property (fetch_start);
endmodule // cfg_exec_properties
bind config_control_instr_exec cfg_exec_properties #(.SELF_CPU(SELF_CPU)) chk (.sys_clk,
	.sys_rst, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .stop_release,
	.mem_req, .mem_ack, .dctl, .dctl_ack, .fetch_start);

//--- verification/cfg_far_side.sv
`timescale 1ns/1ns
module cfg_far_side
	import cfg_ctrl_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic sys_rst, // reset
	input wire logic slow, // answer after extra cycles
	input wire logic halted, // target sits in state 1
	input wire mem_req_t mem_req, // memory request
	output logic mem_ack, // memory ack
	output logic [31:0] mem_rdata, // read word
	input wire dctl_t dctl, // direct control order
	output logic dctl_ack, // order taken
	output logic dctl_tgt_halted, // target halted flag
	output logic [31:0] ext_reg_rdata // target register word
);
	logic [1:0] mc;
	logic [1:0] dc;
	wire mfire = mem_req.req && !mem_ack && mc >= {slow, slow};
	wire dfire = dctl.valid && !dctl_ack && dc >= {slow, slow};
	// outside an answer the data lines toggle so a stale sample cannot match
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_ack <= 1'b0;
			mc <= 2'h0;
			mem_rdata <= 32'h0;
		end else begin
			mem_ack <= mfire;
			mc <= (mem_req.req && !mem_ack) ? mc + 2'h1 : 2'h0;
			mem_rdata <= mfire ? mem_req.addr ^ 32'h0f0f_0f0f : ~mem_rdata;
		end
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dctl_ack <= 1'b0;
			dc <= 2'h0;
			dctl_tgt_halted <= 1'b0;
			ext_reg_rdata <= 32'h0;
		end else begin
			dctl_ack <= dfire;
			dc <= (dctl.valid && !dctl_ack) ? dc + 2'h1 : 2'h0;
			dctl_tgt_halted <= dfire ? halted : !dctl_tgt_halted;
			ext_reg_rdata <= dfire ? {10'h0, dctl.select} : ~ext_reg_rdata;
		end
	end
endmodule // cfg_far_side

//--- verification/test_config_control_instr_exec.sv
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] %0t mismatch got %h exp %h", $time, a, b); end end
module test_config_control_instr_exec;
	import cfg_ctrl_pkg::*;
	localparam int SELF = 1;
	logic sys_clk = 0, sys_rst = 1, stop_release = 0, slow = 0, halted = 1;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rdat, xl1, xl2, comm = 32'h4000_0000, eaddr, sel;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, mem_ack, dctl_ack, dctl_tgt_halted, fetch_start;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, mem_rdata, ext_reg_rdata;
	logic [31:0] scratchpad_memory[4];
	mem_req_t mem_req;
	dctl_t dctl;
	mem_req_t mq[$];
	dctl_t dq[$];
	opcode_t opt[4] = '{OP_LOAD_EXT, OP_STORE_EXT, OP_POWER_DOWN, OP_POWER_UP};
	logic [1:0] ordt[4] = '{ORD_LOAD, ORD_STORE, ORD_PDOWN, ORD_PUP};
	int err_count = 0, check_count = 0, fs = 0, seed = 55, k;
	config_control_instr_exec #(.SELF_CPU(SELF)) DUT (.*);
	cfg_far_side far (.*);
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (mem_req.req && mem_ack) mq.push_back(mem_req);
		if (dctl.valid && dctl_ack) dq.push_back(dctl);
		if (fetch_start) fs++;
	end
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		bit aw, w;
		aw = 0;
		w = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(aw && w)) begin
			@(posedge sys_clk);
			aw = aw | (s_axi_awvalid & s_axi_awready);
			w = w | (s_axi_wvalid & s_axi_wready);
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		while (!s_axi_bvalid) @(posedge sys_clk);
		rsp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		while (!s_axi_rvalid) @(posedge sys_clk);
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic idle;
		int n;
		n = 0;
		do begin
			rd(ADDR_STATUS);
			n++;
		end while (rdat[0] !== 1'b0 && n < 300);
		`CHK(n < 300, 1'b1)
	endtask
	task report_and_stop;
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#400000;
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 0;
		repeat (2) @(posedge sys_clk);
		rd(ADDR_COMM);
		`CHK(rdat[31:29], ST2)
		for (int i = 0; i < 4; i++) begin
			scratchpad_memory[i] = $random(seed);
			axw(ADDR_SPM_BASE + 8'(4 * i), scratchpad_memory[i]);
		end
		// keep pref and comm so the state field stays known
		axw(ADDR_OPERAND, 32'h1c);
		axw(ADDR_CMD, 32'(OP_LOAD_SELF));
		idle();
		xl1 = scratchpad_memory[0];
		xl2 = scratchpad_memory[1];
		rd(ADDR_XLAT1);
		`CHK(rdat, xl1)
		rd(ADDR_XLAT2);
		`CHK(rdat, xl2)
		rd(ADDR_PREF);
		`CHK(rdat, 32'h0)
		rd(ADDR_COMM);
		`CHK(rdat, comm)
		for (int i = 0; i < 4; i++) begin
			axw(ADDR_CMD, 32'(opt[i]));
			idle();
		end
		`CHK(dq.size(), 0)
		`CHK(mq.size(), 0)
		axw(ADDR_CMD, 32'(OP_ENTER_RECONF));
		idle();
		comm[31] = 1'b1;
		rd(ADDR_COMM);
		`CHK(rdat, comm)
		for (int i = 0; i < 4; i++) begin
			k = {$random(seed)} % 15;
			sel = 32'h1 << k;
			slow <= k[0];
			halted <= (i != 2);
			axw(ADDR_SPM_BASE, sel);
			eaddr = $random(seed) & 32'hffff_fffc;
			axw(ADDR_EADDR, eaddr);
			axw(ADDR_CMD, 32'(opt[i]));
			idle();
			`CHK(dq.size(), (i < 2) ? 4 : 1)
			`CHK(mq.size(), (i < 2) ? 4 : 0)
			`CHK(dq[0].order, ordt[i])
			`CHK(dq[0].select, sel[21:0])
			`CHK(dq[0].inhibit, 5'h0)
			if (i < 2) begin
				`CHK(mq[0].addr, eaddr)
				`CHK(mq[0].we, i == 1)
				if (i == 1) `CHK(mq[0].wdata, {10'h0, sel[21:0]})
			end
			if (i == 2) begin
				rd(ADDR_STATUS);
				`CHK(rdat[2], 1'b1)
			end
			dq.delete();
			mq.delete();
		end
		axw(ADDR_SPM_BASE, 32'h1 << (15 + SELF));
		axw(ADDR_CMD, 32'(OP_LOAD_EXT));
		idle();
		`CHK(dq.size(), 0)
		rd(ADDR_STATUS);
		`CHK(rdat[1], 1'b1)
		eaddr = $random(seed) & 32'hffff_fffc;
		axw(ADDR_EADDR, eaddr);
		axw(ADDR_CMD, 32'(OP_STORE_SELF));
		idle();
		`CHK(mq.size(), 4)
		`CHK(mq[0].addr, eaddr)
		`CHK(mq[0].wdata, xl1)
		mq.delete();
		rd(8'h40);
		`CHK(rsp, RESP_SLVERR)
		stop_release <= 1;
		repeat (4) @(posedge sys_clk);
		stop_release <= 0;
		k = 0;
		while (fs == 0 && k < 100) begin
			@(posedge sys_clk);
			k++;
		end
		repeat (4) @(posedge sys_clk);
		`CHK(fs, 1)
		`CHK(mq[0].addr, 32'h0)
		`CHK(mq[0].we, 1'b0)
		`CHK(mq.size(), 1)
		rd(ADDR_RESTART);
		`CHK(rdat, 32'h0f0f_0f0f)
		rd(ADDR_MAR);
		`CHK(rdat, 32'h0)
		report_and_stop();
	end
endmodule // test_config_control_instr_exec
